// File: fifo18_pkg.sv
// Constants and carrier types for the dual-clock 18-bit first-in first-out buffer.
// Assumes both port clocks and all control pins are asynchronous to the core clock.
package fifo18_pkg;

  localparam int DATA_W = 18;
  localparam int DEPTH_DEF = 8192;
  // Default offsets, sliced down to the offset width where they are used.
  localparam logic [15:0] OFFSET_PARALLEL_DEF = 16'h007F;
  localparam logic [15:0] OFFSET_SERIAL_DEF = 16'h03FF;
  // Read clock transitions before a fall-through word appears.
  localparam logic [1:0] FALL_THROUGH_TRANSITIONS = 2'h3;

  // All pins sampled from outside the core clock domain.
  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wen_n;
    logic ren_n;
    logic ld_n;
    logic sen_n;
    logic rt_n;
    logic oe_n;
    logic si;
    logic mr_n;
    logic pr_n;
    logic [DATA_W-1:0] din;
  } pins_type;

endpackage : fifo18_pkg

// File: dual_clock_fifo_18bit.sv
// Dual-clock 18-bit first-in first-out buffer with programmable almost flags.
// Assumes core_clk_i is much faster than either port clock; every pin passes two flip-flops.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module dual_clock_fifo_18bit #(
  parameter int DEPTH = fifo18_pkg::DEPTH_DEF,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  // Core clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Write port.
  input wire logic write_clock_i,
  input wire logic write_enable_n_i,
  input wire logic [fifo18_pkg::DATA_W-1:0] data_in_i,
  // Read port.
  input wire logic read_clock_i,
  input wire logic read_enable_n_i,
  input wire logic output_enable_n_i,
  input wire logic retransmit_n_i,
  // Configuration and programming.
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire logic offset_load_n_i,
  input wire logic serial_shift_enable_n_i,
  input wire logic mode_select_serial_in_i,
  // Data output with three-state control.
  output logic [fifo18_pkg::DATA_W-1:0] data_out_bus_o,
  output logic data_out_bus_oe_n_o,
  // Flags, all active low.
  output logic empty_flag_out_valid_n_o,
  output logic full_flag_in_space_n_o,
  output logic half_full_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o
);
  import fifo18_pkg::*;

  localparam int CNT_W = ADDR_W + 1;
  // Offset registers are never narrower than the larger default, even in a shallow build,
  // so a read-back always returns the default that master reset chose.
  localparam int DEF_W = $clog2(int'(OFFSET_SERIAL_DEF) + 1);
  localparam int OFF_W = (ADDR_W > DEF_W) ? ADDR_W : DEF_W;
  // Thresholds are compared two bits wider than the offsets, so a large offset added to
  // the level can never wrap the sum.
  localparam int CMP_W = OFF_W + 2;

  // Every bit of state except the word array lives in this one struct; the two pin stages come first, then the
  // buffer bookkeeping, then the registered outputs.
  typedef struct packed {
    pins_type s1;
    pins_type s2;
    logic wclk_p;
    logic rclk_p;
    logic fall_through_mode;
    logic serial;
    logic [ADDR_W-1:0] wptr;
    logic [ADDR_W-1:0] rptr;
    logic [OFF_W-1:0] eoff;
    logic [OFF_W-1:0] foff;
    logic [CNT_W-1:0] cnt;
    logic valid;
    logic [1:0] ft_cnt;
    logic rt_hold;
    logic pl_sel;
    logic rb_sel;
    logic [DATA_W-1:0] dout;
    logic oe_n;
    logic ef_n;
    logic ff_n;
    logic hf_n;
    logic ae_n;
    logic af_n;
  } state_type;

  state_type q;
  state_type d;
  pins_type pins;
  pins_type p;
  // The word array sits outside the state struct so that it can map onto block memory.
  logic [DATA_W-1:0] mem [DEPTH];
  // Decoded events of the current core cycle; the pin events come from the second pin stage, empty and full from the state, the level from the next state.
  logic wr_edge;
  logic rd_edge;
  logic rd_trans;
  logic mem_empty;
  logic mem_full;
  logic mem_we;
  logic pop;
  logic rd_req;
  logic [CNT_W-1:0] level;

  // Gather the pins so that one pair of flip-flops handles them all.
  always_comb begin
    pins.wclk = write_clock_i;
    pins.rclk = read_clock_i;
    pins.wen_n = write_enable_n_i;
    pins.ren_n = read_enable_n_i;
    pins.ld_n = offset_load_n_i;
    pins.sen_n = serial_shift_enable_n_i;
    pins.rt_n = retransmit_n_i;
    pins.oe_n = output_enable_n_i;
    pins.si = mode_select_serial_in_i;
    pins.mr_n = master_reset_n_i;
    pins.pr_n = partial_reset_n_i;
    pins.din = data_in_i;
  end

  // Next-state logic. Both port clocks are sampled here, so the two port domains meet in
  // one core domain and the flags never have to cross a clock boundary.
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    p = q.s2;
    d.wclk_p = p.wclk;
    d.rclk_p = p.rclk;
    wr_edge = p.wclk & ~q.wclk_p;
    rd_edge = p.rclk & ~q.rclk_p;
    rd_trans = p.rclk ^ q.rclk_p;
    mem_empty = (q.cnt == '0);
    mem_full = (q.cnt == CNT_W'(DEPTH));
    // A full buffer drops the write; load low keeps the write out of the buffer and steers it to the offsets in parallel mode only.
    mem_we = wr_edge & ~p.wen_n & p.ld_n & ~mem_full & p.mr_n & p.pr_n;
    rd_req = rd_edge & ~p.ren_n & p.ld_n & p.rt_n & ~q.rt_hold;
    pop = 1'b0;
    if (q.fall_through_mode) begin
      // The first word falls through on its own; later ones wait for an enabled read.
      if (!q.valid && q.ft_cnt == FALL_THROUGH_TRANSITIONS && !mem_empty) begin
        pop = 1'b1;
        d.valid = 1'b1;
      end else if (rd_req && q.valid) begin
        pop = ~mem_empty;
        d.valid = ~mem_empty;
      end
      if (q.valid || mem_empty || q.rt_hold) begin
        d.ft_cnt = '0;
      end else if (rd_trans && q.ft_cnt != FALL_THROUGH_TRANSITIONS) begin
        d.ft_cnt = q.ft_cnt + 2'h1;
      end
    end else begin
      pop = rd_req & ~mem_empty;
    end
    if (pop) begin
      d.dout = mem[q.rptr];
      d.rptr = q.rptr + ADDR_W'(1);
    end
    if (mem_we) begin
      d.wptr = q.wptr + ADDR_W'(1);
    end
    d.cnt = q.cnt + CNT_W'(mem_we) - CNT_W'(pop);
    // Offset read-back alternates empty then full offset, whatever the load method.
    if (rd_edge && !p.ren_n && !p.ld_n) begin
      d.dout = q.rb_sel ? DATA_W'(q.foff) : DATA_W'(q.eoff);
      d.rb_sel = ~q.rb_sel;
    end
    // Offset programming by the method chosen at master reset.
    // Programming is refused during either reset, so a partial reset keeps the offsets.
    if (wr_edge && !p.ld_n && p.mr_n && p.pr_n) begin
      if (!q.serial && !p.wen_n) begin
        if (q.pl_sel) begin
          d.foff = p.din[OFF_W-1:0];
        end else begin
          d.eoff = p.din[OFF_W-1:0];
        end
        d.pl_sel = ~q.pl_sel;
      end else if (q.serial && !p.sen_n) begin
        {d.foff, d.eoff} = {q.foff[OFF_W-2:0], q.eoff, p.si};
      end
    end
    // A retransmit shows empty for one read edge while the first word is refetched.
    if (rd_edge) begin
      d.rt_hold = 1'b0;
    end
    if (rd_edge && !p.rt_n) begin
      d.rptr = '0;
      d.cnt = CNT_W'(d.wptr);
      d.valid = 1'b0;
      d.ft_cnt = '0;
      d.rt_hold = 1'b1;
    end
    // Partial reset keeps mode, method and offsets.
    if (!p.pr_n) begin
      d.wptr = '0;
      d.rptr = '0;
      d.cnt = '0;
      d.valid = 1'b0;
      d.ft_cnt = '0;
      d.rt_hold = 1'b0;
      d.pl_sel = 1'b0;
      d.rb_sel = 1'b0;
      d.dout = '0;
    end
    // Master reset catches the straps while it is held.
    if (!p.mr_n) begin
      d.wptr = '0;
      d.rptr = '0;
      d.cnt = '0;
      d.valid = 1'b0;
      d.ft_cnt = '0;
      d.rt_hold = 1'b0;
      d.pl_sel = 1'b0;
      d.rb_sel = 1'b0;
      d.dout = '0;
      d.fall_through_mode = p.si;
      d.serial = p.ld_n;
      d.eoff = p.ld_n ? OFFSET_SERIAL_DEF[OFF_W-1:0]
                      : OFFSET_PARALLEL_DEF[OFF_W-1:0];
      d.foff = d.eoff;
    end
    // Flags come from the next state, so every reset lands on flags for the mode in force.
    level = d.cnt + CNT_W'(d.fall_through_mode & d.valid);
    d.ef_n = d.fall_through_mode ? ~d.valid : ~((d.cnt == '0) | d.rt_hold);
    d.ff_n = d.fall_through_mode ? (d.cnt == CNT_W'(DEPTH)) : (d.cnt != CNT_W'(DEPTH));
    d.hf_n = ~(level > CNT_W'(DEPTH / 2));
    // Almost-full is tested as level plus offset above capacity, which cannot go negative
    // when an offset larger than the depth is programmed.
    d.ae_n = ~(CMP_W'(level) < CMP_W'(d.eoff));
    d.af_n = ~(CMP_W'(level) + CMP_W'(d.foff) > CMP_W'(DEPTH));
    d.oe_n = p.oe_n;
  end

  // State register; the reset values describe an empty buffer with outputs floating.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.oe_n <= 1'b1;
      q.ff_n <= 1'b1;
      q.hf_n <= 1'b1;
      q.af_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Storage array; no reset so it can map onto block memory.
  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[q.wptr] <= p.din;
    end
  end

  // Outputs straight from the state register.
  assign data_out_bus_o = q.dout;
  assign data_out_bus_oe_n_o = q.oe_n;
  assign empty_flag_out_valid_n_o = q.ef_n;
  assign full_flag_in_space_n_o = q.ff_n;
  assign half_full_flag_n_o = q.hf_n;
  assign almost_empty_flag_n_o = q.ae_n;
  assign almost_full_flag_n_o = q.af_n;

  // Checks on the design's own state. The reset and strap pins are read from the second
  // pin stage, the same values that the next-state logic used in that cycle, so each
  // check compares like with like. All of them sleep while the core reset is held.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_count_bound;
    q.cnt <= CNT_W'(DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("word count above capacity");

  property p_full_drops_write;
    (mem_full && wr_edge && !pop && q.s2.mr_n && q.s2.pr_n && q.s2.rt_n) |=> $stable(q.wptr);
  endproperty
  a_full_drops_write: assert property (p_full_drops_write) else $error("write taken while full");

  property p_master_ptrs;
    !q.s2.mr_n |=> (q.wptr == '0 && q.rptr == '0 && q.cnt == '0);
  endproperty
  a_master_ptrs: assert property (p_master_ptrs) else $error("pointers not cleared by master reset");

  property p_master_default;
    (!q.s2.mr_n && !q.s2.ld_n) |=> (q.eoff == OFF_W'(127) && q.foff == OFF_W'(127) && !q.serial);
  endproperty
  a_master_default: assert property (p_master_default) else $error("parallel default offset wrong");

  property p_partial_keeps;
    (!q.s2.pr_n && q.s2.mr_n) |=> ($stable(q.fall_through_mode) && $stable(q.serial) && q.wptr == '0);
  endproperty
  a_partial_keeps: assert property (p_partial_keeps) else $error("partial reset changed settings");

  property p_oe_follows;
    q.s2.oe_n |=> data_out_bus_oe_n_o;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("output driven while disabled");

  property p_retransmit;
    (rd_edge && !q.s2.rt_n && q.s2.mr_n && q.s2.pr_n) |=>
      (q.rptr == '0 && (q.fall_through_mode ? q.ef_n : !q.ef_n) ##1 !q.valid);
  endproperty
  a_retransmit: assert property (p_retransmit) else $error("retransmit did not rewind");

  property p_std_no_spontaneous;
    (!q.fall_through_mode && !rd_edge && q.s2.mr_n && q.s2.pr_n) |=> $stable(q.dout);
  endproperty
  a_std_no_spontaneous: assert property (p_std_no_spontaneous) else $error("data moved unasked");

  property p_serial_shift;
    (q.serial && wr_edge && !q.s2.ld_n && !q.s2.sen_n && q.s2.mr_n) |=> (q.eoff[0] == $past(q.s2.si));
  endproperty
  a_serial_shift: assert property (p_serial_shift) else $error("serial bit not shifted in");

  property p_almost_full;
    (q.s2.mr_n && q.s2.pr_n) |=> (!q.af_n == (CMP_W'(q.cnt) + CMP_W'(q.fall_through_mode & q.valid) +
      CMP_W'(q.foff) > CMP_W'(DEPTH)));
  endproperty
  a_almost_full: assert property (p_almost_full) else $error("almost-full flag wrong");

  property p_ft_word_held;
    (q.fall_through_mode && q.valid && !rd_edge && q.s2.rt_n && q.s2.mr_n && q.s2.pr_n) |=> q.valid;
  endproperty
  a_ft_word_held: assert property (p_ft_word_held) else $error("fall-through word lost");

  property p_half_full;
    (q.s2.mr_n && q.s2.pr_n) |=>
      (!q.hf_n == (q.cnt + CNT_W'(q.fall_through_mode & q.valid) > CNT_W'(DEPTH / 2)));
  endproperty
  a_half_full: assert property (p_half_full) else $error("half-full flag wrong");

  property p_almost_empty;
    (q.s2.mr_n && q.s2.pr_n) |=>
      (!q.ae_n == (CMP_W'(q.cnt) + CMP_W'(q.fall_through_mode & q.valid) < CMP_W'(q.eoff)));
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost-empty flag wrong");

  property p_std_empty_flag;
    (!q.fall_through_mode && q.cnt != '0 && !q.rt_hold) |-> q.ef_n;
  endproperty
  a_std_empty_flag: assert property (p_std_empty_flag) else $error("empty shown with data");

  property p_ft_ready;
    q.fall_through_mode |-> (q.ef_n == !q.valid);
  endproperty
  a_ft_ready: assert property (p_ft_ready) else $error("output-ready disagrees with word");

  property p_std_full_flag;
    !q.fall_through_mode |-> (q.ff_n == (q.cnt != CNT_W'(DEPTH)));
  endproperty
  a_std_full_flag: assert property (p_std_full_flag) else $error("full flag wrong");

  property p_partial_ptrs;
    !q.s2.pr_n |=> (q.wptr == '0 && q.rptr == '0 && q.cnt == '0);
  endproperty
  a_partial_ptrs: assert property (p_partial_ptrs) else $error("partial reset left pointers");

  property p_partial_offsets;
    (!q.s2.pr_n && q.s2.mr_n) |=> ($stable(q.eoff) && $stable(q.foff));
  endproperty
  a_partial_offsets: assert property (p_partial_offsets) else $error("offsets lost");

  property p_retx_keeps;
    (rd_edge && !q.s2.rt_n && q.s2.mr_n && q.s2.pr_n && !mem_we) |=>
      ($stable(q.wptr) && $stable(q.fall_through_mode) && $stable(q.serial));
  endproperty
  a_retx_keeps: assert property (p_retx_keeps) else $error("retransmit moved write side");

  property p_ft_fall_in;
    (q.fall_through_mode && !q.valid && q.ft_cnt == FALL_THROUGH_TRANSITIONS && !mem_empty && q.s2.rt_n &&
      q.s2.mr_n && q.s2.pr_n) |=> q.valid;
  endproperty
  a_ft_fall_in: assert property (p_ft_fall_in) else $error("first word did not fall");

  property p_master_serial;
    (!q.s2.mr_n && q.s2.ld_n) |=>
      (q.eoff == OFF_W'(1023) && q.foff == OFF_W'(1023) && q.serial);
  endproperty
  a_master_serial: assert property (p_master_serial) else $error("serial default wrong");

  // Covers show that each main scenario was reached at least once in a run.
  c_fall_through: cover property (q.fall_through_mode && !q.valid ##1 q.valid);
  c_retransmit: cover property (rd_edge && !q.s2.rt_n && q.cnt != '0);
  c_full: cover property (mem_full);
  c_readback: cover property (rd_edge && !q.s2.ren_n && !q.s2.ld_n);
  c_serial: cover property (q.serial && wr_edge && !q.s2.sen_n && !q.s2.ld_n);

endmodule : dual_clock_fifo_18bit

// File: link_agent.sv
// Writer and reader model that drives the buffer's port pins from the core clock.
// Assumes a 200 MHz core clock, so a port clock high for 8 of its 24 core cycles has a 120 ns period.
`timescale 1ns/100ps
module link_agent
  import fifo18_pkg::*;
(
  // Core clock and read data.
  input wire logic core_clk_i,
  input wire logic [fifo18_pkg::DATA_W-1:0] dout_i,
  // Port pins.
  output logic wclk_o,
  output logic wen_n_o,
  output logic [fifo18_pkg::DATA_W-1:0] din_o,
  output logic rclk_o,
  output logic ren_n_o,
  output logic rt_n_o,
  output logic ld_n_o,
  output logic sen_n_o
);
  // Port clocks stand still between frames, so no stray edge is ever counted.
  initial begin
    {wclk_o, rclk_o} = 2'b00;
    {wen_n_o, ren_n_o, rt_n_o, ld_n_o, sen_n_o} = 5'b11111;
    din_o = 18'h0_0000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick

  // Levels settle 8 core cycles before the rise; idle data is inverted, never left stale.
  task automatic wr_cycle(input logic [DATA_W-1:0] d, input logic ld);
    wen_n_o <= 1'b0;
    ld_n_o <= ld;
    din_o <= d;
    tick(8);
    wclk_o <= 1'b1;
    tick(8);
    wclk_o <= 1'b0;
    {wen_n_o, ld_n_o} <= 2'b11;
    din_o <= ~d;
    tick(8);
  endtask : wr_cycle

  // One read clock period; the answer is taken long after its 3 to 4 cycle latency.
  task automatic rd_cycle(input logic ren, input logic ld, input logic rt,
                          output logic [DATA_W-1:0] d);
    ren_n_o <= ren;
    ld_n_o <= ld;
    rt_n_o <= rt;
    tick(8);
    rclk_o <= 1'b1;
    tick(8);
    rclk_o <= 1'b0;
    {ren_n_o, ld_n_o, rt_n_o} <= 3'b111;
    tick(8);
    d = dout_i;
  endtask : rd_cycle

  // One serial offset bit; the bench puts the bit on the serial input beforehand.
  task automatic sen_cycle();
    sen_n_o <= 1'b0;
    ld_n_o <= 1'b0;
    tick(8);
    wclk_o <= 1'b1;
    tick(8);
    wclk_o <= 1'b0;
    {sen_n_o, ld_n_o} <= 2'b11;
    tick(8);
  endtask : sen_cycle

  task automatic strap_ld(input logic v);
    ld_n_o <= v;
  endtask : strap_ld
endmodule : link_agent

// File: testbench.sv
// Self-checking bench for the dual-clock buffer, run with a depth of 64 to keep fills short.
// Assumes link_agent drives the port pins; the bench owns resets, straps and output enable.
`timescale 1ns/100ps
module testbench;
  import fifo18_pkg::*;
  localparam int DEPTH = 64;
  // Full offset 4 above empty offset 1, ten bits each at this depth.
  localparam logic [19:0] SER_OFFS = 20'h0_1001;
  logic core_clk, rst_n, mr_n, pr_n, oe_n, si, oe_o;
  logic wclk, wen_n, rclk, ren_n, rt_n, ld_n, sen_n;
  logic [DATA_W-1:0] din, dout, rd;
  logic [4:0] flags;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  dual_clock_fifo_18bit #(.DEPTH(DEPTH)) i_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .write_clock_i(wclk),
    .write_enable_n_i(wen_n), .data_in_i(din), .read_clock_i(rclk),
    .read_enable_n_i(ren_n), .output_enable_n_i(oe_n), .retransmit_n_i(rt_n),
    .master_reset_n_i(mr_n), .partial_reset_n_i(pr_n), .offset_load_n_i(ld_n),
    .serial_shift_enable_n_i(sen_n), .mode_select_serial_in_i(si),
    .data_out_bus_o(dout), .data_out_bus_oe_n_o(oe_o),
    .empty_flag_out_valid_n_o(flags[4]), .full_flag_in_space_n_o(flags[3]),
    .half_full_flag_n_o(flags[2]), .almost_empty_flag_n_o(flags[1]),
    .almost_full_flag_n_o(flags[0]));

  link_agent i_agent (.core_clk_i(core_clk), .dout_i(dout), .wclk_o(wclk),
    .wen_n_o(wen_n), .din_o(din), .rclk_o(rclk), .ren_n_o(ren_n), .rt_n_o(rt_n),
    .ld_n_o(ld_n), .sen_n_o(sen_n));

  // Core clock of 5 ns.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Straps are held across the whole reset pulse and well past its two-stage synchroniser.
  task automatic rst_pulse(input logic mode, input logic ld, input logic part);
    @(posedge core_clk);
    si <= mode;
    i_agent.strap_ld(ld);
    if (part)
      pr_n <= 1'b0;
    else
      mr_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    {mr_n, pr_n} <= 2'b11;
    repeat (6) @(posedge core_clk);
    i_agent.strap_ld(1'b1);
  endtask : rst_pulse

  // A hang is cut short long after the expected run of about 4,200 cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {rst_n, mr_n, pr_n, oe_n, si} = 5'b00100;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rst_pulse(1'b0, 1'b0, 1'b0);
    chk(18'(flags[4:1]), 18'(4'b0110));
    for (int k = 0; k < 2; k++) begin
      i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
      chk(rd, 18'h0_007F);
    end
    i_agent.rd_cycle(1'b0, 1'b1, 1'b1, rd);
    chk(rd, 18'h0_007F);
    i_agent.wr_cycle(18'h0_0002, 1'b0);
    i_agent.wr_cycle(18'h0_0005, 1'b0);
    i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
    chk(rd, 18'h0_0002);
    i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
    chk(rd, 18'h0_0005);
    $display("test offsets done");
    // The last write lands on a full buffer and must leave the flags alone.
    for (int i = 1; i <= DEPTH + 1; i++) begin
      i_agent.wr_cycle(18'h2_A000 + 18'(i), 1'b1);
      chk(18'(flags), 18'({1'b1, i < DEPTH, i <= DEPTH / 2, i >= 2, i <= DEPTH - 5}));
    end
    for (int i = 1; i <= DEPTH; i++) begin
      i_agent.rd_cycle(1'b0, 1'b1, 1'b1, rd);
      chk(rd, 18'h2_A000 + 18'(i));
    end
    chk(18'(flags[4]), 18'h0_0000);
    $display("test fill and drain done");
    rst_pulse(1'b0, 1'b1, 1'b1);
    chk(18'(flags[4:1]), 18'(4'b0110));
    for (int i = 0; i < 3; i++)
      i_agent.wr_cycle(18'h1_5550 + 18'(i), 1'b1);
    chk(18'(flags[1]), 18'h0_0001);
    i_agent.rd_cycle(1'b0, 1'b1, 1'b1, rd);
    chk(rd, 18'h1_5550);
    i_agent.rd_cycle(1'b1, 1'b1, 1'b0, rd);
    chk(18'(flags[4]), 18'h0_0000);
    i_agent.rd_cycle(1'b1, 1'b1, 1'b1, rd);
    for (int i = 0; i < 3; i++) begin
      i_agent.rd_cycle(1'b0, 1'b1, 1'b1, rd);
      chk(rd, 18'h1_5550 + 18'(i));
    end
    @(posedge core_clk);
    oe_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(18'(oe_o), 18'h0_0001);
    oe_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(18'(oe_o), 18'h0_0000);
    $display("test partial reset and retransmit done");
    rst_pulse(1'b1, 1'b1, 1'b0);
    i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
    chk(rd, 18'h0_03FF);
    chk(18'(flags[4:3]), 18'(2'b10));
    i_agent.wr_cycle(18'h3_1234, 1'b1);
    chk(18'(flags[4]), 18'h0_0001);
    i_agent.rd_cycle(1'b1, 1'b1, 1'b1, rd);
    chk(18'(flags[4]), 18'h0_0001);
    i_agent.rd_cycle(1'b1, 1'b1, 1'b1, rd);
    chk(rd, 18'h3_1234);
    chk(18'(flags[4]), 18'h0_0000);
    i_agent.wr_cycle(18'h3_5678, 1'b1);
    chk(dout, 18'h3_1234);
    i_agent.rd_cycle(1'b0, 1'b1, 1'b1, rd);
    chk(rd, 18'h3_5678);
    $display("test fall-through done");
    // Serial offsets: full offset bits first, then empty, each most significant bit first.
    for (int b = 19; b >= 0; b--) begin
      si <= SER_OFFS[b];
      i_agent.sen_cycle();
    end
    i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
    chk(rd, 18'h0_0004);
    i_agent.rd_cycle(1'b0, 1'b0, 1'b1, rd);
    chk(rd, 18'h0_0001);
    chk(18'(flags[1]), 18'h0_0001);
    $display("test serial offsets done");
    close_out();
  end
endmodule : testbench
